// ===== src/timer_channel_mode_config.v
// one timer channel with its mode configuration register on an AXI4-Lite slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// RQ1: mode register accessed as one 16-bit unit
// RQ2: software writes only while counter stopped
// RQ3: bits 15:14 pick prescaled operation clock
// RQ4: op clock drives trigger edge detection
// RQ5: bits 13:12 pick op clock or trigger
// RQ6: bit 11 sets master or slave role
// RQ7: mode change while stopped: restart value undefined
// RQ8: writes while running are ignored
module timer_channel_mode_config
#(
  parameter EVEN_CHANNEL = 1,
  parameter CNT_WIDTH = 32
)
(
  input wire i_ref_clk,
  input wire i_reset_n,
  // write address channel
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // prescaled clock ticks 0..3, one-cycle pulses from the prescaler
  input wire [3:0] i_prescaled_clock,
  // external trigger pin of the channel
  input wire i_channel_trigger_input,
  output reg [CNT_WIDTH-1:0] o_channel_counter,
  output reg o_counter_enable_status,
  output reg o_master_slave_role,
  output reg o_count_tick
);
`include "timer_cfg_map.vh"

// held write address and data
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
// stored configuration
reg [15:0] channel_mode_config;
reg [1:0] trig_edge_select;
// sticky flag: a config write was refused
reg write_rejected;
// mode field changed since the last start
reg mode_changed;
// decoded write actions
wire do_write;
wire wr_cfg;
wire wr_ctrl;
wire wr_status;
wire wr_edge;
wire wr_known;
wire start_req;
wire stop_req;
wire cfg_lanes_ok;
wire op_tick;
wire valid_edge;
wire count_tick;
reg [31:0] next_rdata;
reg [1:0] next_rresp;

// channel fields
wire [1:0] op_clock_select;
wire [1:0] count_clock_select;
wire [4:0] operating_mode_field;

assign op_clock_select = channel_mode_config[`OP_CLK_MSB:`OP_CLK_LSB];
assign count_clock_select = channel_mode_config[`CNT_CLK_MSB:`CNT_CLK_LSB];
assign operating_mode_field = channel_mode_config[`OP_MODE_MSB:`OP_MODE_LSB];

// each address/data channel takes one item and waits for its partner
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
// read answered one cycle after acceptance
assign s_axi_arready = ~s_axi_rvalid;

// write happens once both halves are held
assign do_write = aw_held & w_held & ~s_axi_bvalid;
assign wr_cfg = do_write & (aw_addr == `ADDR_CHAN_MODE_CFG);
assign wr_ctrl = do_write & (aw_addr == `ADDR_CHAN_CTRL);
assign wr_status = do_write & (aw_addr == `ADDR_CHAN_STATUS);
assign wr_edge = do_write & (aw_addr == `ADDR_TRIG_EDGE);
assign wr_known = (aw_addr == `ADDR_CHAN_MODE_CFG) | (aw_addr == `ADDR_CHAN_CTRL) |
                  (aw_addr == `ADDR_CHAN_STATUS) | (aw_addr == `ADDR_TRIG_EDGE) |
                  (aw_addr == `ADDR_CHAN_COUNT);
// RQ1: both low lanes required
assign cfg_lanes_ok = ((w_strb & `LANES_16) == `LANES_16);
assign start_req = wr_ctrl & w_strb[0] & w_data[`CTRL_START_BIT];
assign stop_req = wr_ctrl & w_strb[0] & w_data[`CTRL_STOP_BIT];

// address and data capture, response generation
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    aw_addr <= 8'h00;
    aw_held <= 1'b0;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    w_held <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end
  else
  begin
    // address taken independently of data
    if (s_axi_awvalid & s_axi_awready)
    begin
      aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      aw_held <= 1'b1;
    end
    // data taken independently of address
    if (s_axi_wvalid & s_axi_wready)
    begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      w_held <= 1'b1;
    end
    if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      // unmapped address gets an error answer
      s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bvalid & s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

// configuration storage
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    channel_mode_config <= `MODE_CFG_RESET;
    trig_edge_select <= `TRIG_EDGE_RESET;
    mode_changed <= 1'b0;
  end
  else
  begin
    // RQ8: running counter blocks writes
    if (wr_cfg & cfg_lanes_ok & ~o_counter_enable_status)
    begin
      // RQ1: full 16-bit word stored
      channel_mode_config <= w_data[15:0];
      // RQ7: note mode field change
      if (w_data[`OP_MODE_MSB:`OP_MODE_LSB] != operating_mode_field)
      begin
        mode_changed <= 1'b1;
      end
    end
    else if (start_req & ~o_counter_enable_status)
    begin
      // restart consumes the change marker
      mode_changed <= 1'b0;
    end
    // edge choice follows the same stop-only policy
    if (wr_edge & w_strb[0] & ~o_counter_enable_status)
    begin
      trig_edge_select <= w_data[1:0];
    end
  end
end

// refused-write flag; a refusal in the clearing cycle wins
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    write_rejected <= 1'b0;
  end
  else
  begin
    // RQ2: refusal recorded for software
    if (wr_cfg & (o_counter_enable_status | ~cfg_lanes_ok))
    begin
      write_rejected <= 1'b1;
    end
    else if (wr_status & w_strb[0] & w_data[`STAT_REJECT_BIT])
    begin
      write_rejected <= 1'b0;
    end
  end
end

// run state: start and stop commands, stop wins if both set
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    o_counter_enable_status <= 1'b0;
  end
  else if (stop_req)
  begin
    o_counter_enable_status <= 1'b0;
  end
  else if (start_req)
  begin
    o_counter_enable_status <= 1'b1;
  end
end

// RQ4: op tick feeds edge detection
trig_edge_detect u_trig_edge_detect
(
  .i_ref_clk(i_ref_clk),
  .i_reset_n(i_reset_n),
  .i_trigger_pin(i_channel_trigger_input),
  .i_op_tick(op_tick),
  .i_edge_select(trig_edge_select),
  .o_valid_edge(valid_edge)
);

// RQ3: prescaled clock chosen by field
// RQ5: count source chosen by field
count_tick_select u_count_tick_select
(
  .i_prescaled_ticks(i_prescaled_clock),
  .i_op_clock_select(op_clock_select),
  .i_count_clock_select(count_clock_select),
  .i_valid_edge(valid_edge),
  .o_op_tick(op_tick),
  .o_count_tick(count_tick)
);

// channel counter, an up counter; mode-specific behaviour lives elsewhere
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    o_channel_counter <= {CNT_WIDTH{1'b0}};
    o_count_tick <= 1'b0;
  end
  else
  begin
    o_count_tick <= count_tick & o_counter_enable_status;
    // RQ7: changed mode restarts from zero
    if (start_req & ~o_counter_enable_status & mode_changed)
    begin
      o_channel_counter <= {CNT_WIDTH{1'b0}};
    end
    else if (count_tick & o_counter_enable_status)
    begin
      o_channel_counter <= o_channel_counter + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end
end

// RQ6: role only meaningful on even channels
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    o_master_slave_role <= 1'b0;
  end
  else
  begin
    o_master_slave_role <= (EVEN_CHANNEL != 0) & channel_mode_config[`ROLE_BIT];
  end
end

// read data mux
always @*
begin
  next_rdata = 32'h00000000;
  next_rresp = `RESP_OKAY;
  case ({s_axi_araddr[7:2], 2'b00})
    `ADDR_CHAN_MODE_CFG: next_rdata = {16'h0000, channel_mode_config};
    `ADDR_CHAN_CTRL: next_rdata = 32'h00000000;
    `ADDR_CHAN_STATUS: next_rdata = {30'h00000000, write_rejected, o_counter_enable_status};
    `ADDR_CHAN_COUNT: next_rdata = o_channel_counter[31:0];
    `ADDR_TRIG_EDGE: next_rdata = {30'h00000000, trig_edge_select};
    // unmapped reads return zero with an error
    default: next_rresp = `RESP_SLVERR;
  endcase
end

// read answer registered, held until taken
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `RESP_OKAY;
  end
  else if (s_axi_arvalid & s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata <= next_rdata;
    s_axi_rresp <= next_rresp;
  end
  else if (s_axi_rvalid & s_axi_rready)
  begin
    s_axi_rvalid <= 1'b0;
  end
end
endmodule // timer_channel_mode_config

// ===== src/timer_cfg_map.vh
// register offsets, field positions and reset values of the timer channel
`ifndef TIMER_CFG_MAP_VH
`define TIMER_CFG_MAP_VH
`define ADDR_CHAN_CTRL 8'h00
`define ADDR_CHAN_STATUS 8'h04
`define ADDR_CHAN_COUNT 8'h08
`define ADDR_TRIG_EDGE 8'h0C
`define ADDR_CHAN_MODE_CFG 8'h80
`define MODE_CFG_RESET 16'h0000
`define TRIG_EDGE_RESET 2'h0
`define OP_CLK_MSB 15
`define OP_CLK_LSB 14
`define CNT_CLK_MSB 13
`define CNT_CLK_LSB 12
`define ROLE_BIT 11
`define OP_MODE_MSB 4
`define OP_MODE_LSB 0
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define STAT_ENABLE_BIT 0
`define STAT_REJECT_BIT 1
`define CNT_CLK_OPCLK 2'h0
`define CNT_CLK_TRIG 2'h1
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`define LANES_16 4'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== src/trig_edge_detect.v
// trigger pin synchroniser and valid-edge detector clocked by the op clock tick
`timescale 1ns/1ps
module trig_edge_detect
(
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_trigger_pin,
  input wire i_op_tick,
  input wire [1:0] i_edge_select,
  output reg o_valid_edge
);
`include "timer_cfg_map.vh"

// two-stage synchroniser, first stage read only by the second
reg sync_meta;
reg sync_level;
// level seen at the previous op clock tick
reg sampled_level;
// edge kinds seen at this tick
wire rise_seen;
wire fall_seen;
reg next_valid_edge;

// pin crosses into the reference clock domain
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    sync_meta <= 1'b0;
    sync_level <= 1'b0;
  end
  else
  begin
    sync_meta <= i_trigger_pin;
    sync_level <= sync_meta;
  end
end

assign rise_seen = sync_level & ~sampled_level;
assign fall_seen = ~sync_level & sampled_level;

// choose which edge counts as valid
always @*
begin
  case (i_edge_select)
    `EDGE_RISE: next_valid_edge = rise_seen;
    `EDGE_FALL: next_valid_edge = fall_seen;
    `EDGE_BOTH: next_valid_edge = rise_seen | fall_seen;
    // unused code detects nothing
    default: next_valid_edge = 1'b0;
  endcase
end

// sampling only on the op tick, so slow op clocks filter short glitches
always @(posedge i_ref_clk or negedge i_reset_n)
begin
  if (!i_reset_n)
  begin
    sampled_level <= 1'b0;
    o_valid_edge <= 1'b0;
  end
  else
  begin
    o_valid_edge <= 1'b0;
    if (i_op_tick)
    begin
      sampled_level <= sync_level;
      o_valid_edge <= next_valid_edge;
    end
  end
end
endmodule // trig_edge_detect

// ===== src/count_tick_select.v
// operation clock and count clock selection for one channel
`timescale 1ns/1ps
module count_tick_select
(
  input wire [3:0] i_prescaled_ticks,
  input wire [1:0] i_op_clock_select,
  input wire [1:0] i_count_clock_select,
  input wire i_valid_edge,
  output wire o_op_tick,
  output reg o_count_tick
);
`include "timer_cfg_map.vh"

// one of the four prescaled ticks by index
assign o_op_tick = i_prescaled_ticks[i_op_clock_select];

// count source: op tick or trigger edge; prohibited codes count nothing
always @*
begin
  case (i_count_clock_select)
    `CNT_CLK_OPCLK: o_count_tick = o_op_tick;
    `CNT_CLK_TRIG: o_count_tick = i_valid_edge;
    default: o_count_tick = 1'b0;
  endcase
end
endmodule // count_tick_select

// ===== sim/timer_channel_mode_config_monitor.sv
// checker of bus handshakes and counter behaviour
`timescale 1ns/1ps
module timer_channel_mode_config_monitor
#(
  parameter CNT_WIDTH = 32
)
(
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] i_prescaled_clock,
  input wire [CNT_WIDTH-1:0] o_channel_counter,
  input wire o_counter_enable_status,
  input wire o_count_tick
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // address and data taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // counter held stopped for two samples
  sequence s_stopped;
    !o_counter_enable_status [*2];
  endsequence
  // halves held at the take edge, write done at the next, answer seen one later
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_stop_freeze: assert property (s_stopped |-> $stable(o_channel_counter))
    else $error("counter moved while stopped");
  a_no_tick_stopped: assert property (s_stopped |-> !o_count_tick)
    else $error("count tick while stopped");
  a_tick_cause: assert property (o_count_tick |-> $past(i_prescaled_clock) != 4'h0 ||
    $past(i_prescaled_clock, 2) != 4'h0 || $past(i_prescaled_clock, 3) != 4'h0)
    else $error("count tick without prescaled tick");
endmodule // timer_channel_mode_config_monitor

bind timer_channel_mode_config timer_channel_mode_config_monitor #(.CNT_WIDTH(CNT_WIDTH)) mon_i
(
  .i_ref_clk, .i_reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .i_prescaled_clock, .o_channel_counter, .o_counter_enable_status, .o_count_tick
);

// ===== sim/timer_channel_mode_config_tb_top.sv
// self-checking bench for the channel mode register block
`timescale 1ns/1ps
`include "timer_cfg_map.vh"
module timer_channel_mode_config_tb_top;
  logic i_ref_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, i_prescaled_clock = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // answers are always accepted at once
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, i_channel_trigger_input = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire o_counter_enable_status, o_master_slave_role, o_count_tick;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, o_channel_counter;
  int failures = 0, tests_run = 0;
  logic [31:0] d, cnt = 32'h0;
  logic [1:0] r;

  timer_channel_mode_config timer_channel_mode_config_i
  (
    .i_ref_clk, .i_reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .i_prescaled_clock, .i_channel_trigger_input, .o_channel_counter,
    .o_counter_enable_status, .o_master_slave_role, .o_count_tick
  );

  // 200 MHz reference clock
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a wait that ran out ends the run
  task automatic guard(input int n);
    if (n >= 50)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge i_ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    guard(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge i_ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    guard(n);
  endtask

  // one-cycle tick pulses on the chosen lanes
  task automatic pulse(input logic [3:0] m, input int k);
    repeat (k)
    begin
      i_prescaled_clock <= m;
      @(posedge i_ref_clk);
      i_prescaled_clock <= 4'h0;
      @(posedge i_ref_clk);
    end
  endtask

  // trigger pin pulsed k times while ticks m run; caller clears the ticks
  task automatic toggle(input logic [3:0] m, input int k);
    i_prescaled_clock <= m;
    repeat (k)
    begin
      i_channel_trigger_input <= 1'h1;
      repeat (8) @(posedge i_ref_clk);
      i_channel_trigger_input <= 1'h0;
      repeat (8) @(posedge i_ref_clk);
    end
  endtask

  // each op clock choice counts only its own lane; role follows bit 11
  task automatic t_clocks;
    logic [31:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = {16'h0, k[1:0], 2'h0, k[0], 11'h0};
      wr(`ADDR_CHAN_MODE_CFG, v, `LANES_16);
      rd(`ADDR_CHAN_MODE_CFG);
      chk("mode cfg", v, d);
      chk("role", {31'h0, k[0]}, {31'h0, o_master_slave_role});
      wr(`ADDR_CHAN_CTRL, 32'h1, 4'hF);
      pulse(~(4'h1 << k), 2);
      chk("no tick other lane", 32'h0, {31'h0, o_count_tick});
      pulse(4'h1 << k, 3);
      chk("count tick", 32'h1, {31'h0, o_count_tick});
      wr(`ADDR_CHAN_CTRL, 32'h2, 4'hF);
      cnt = cnt + 32'h3;
      rd(`ADDR_CHAN_COUNT);
      chk("count op clock", cnt, d);
    end
  endtask

  // trigger edges count only in source 01; 10 and 11 count nothing
  task automatic t_sources;
    for (int c = 1; c < 4; c++)
    begin
      wr(`ADDR_CHAN_MODE_CFG, {18'h0, c[1:0], 12'h0}, `LANES_16);
      wr(`ADDR_CHAN_CTRL, 32'h1, 4'hF);
      toggle(4'hF, 2);
      i_prescaled_clock <= 4'h0;
      wr(`ADDR_CHAN_CTRL, 32'h2, 4'hF);
      cnt = cnt + ((c == 1) ? 32'h2 : 32'h0);
      rd(`ADDR_CHAN_COUNT);
      chk("count trigger", cnt, d);
    end
  endtask

  // only op clock 2 samples the pin; fall, both and none edge kinds
  task automatic t_edges;
    for (int e = 1; e < 4; e++)
    begin
      wr(`ADDR_CHAN_MODE_CFG, 32'h9000, `LANES_16);
      wr(`ADDR_TRIG_EDGE, e, 4'hF);
      rd(`ADDR_TRIG_EDGE);
      chk("edge select", e, d);
      wr(`ADDR_CHAN_CTRL, 32'h1, 4'hF);
      toggle(4'hB, 1);
      toggle(4'h4, 2);
      i_prescaled_clock <= 4'h0;
      wr(`ADDR_CHAN_CTRL, 32'h2, 4'hF);
      cnt = cnt + ((e == 3) ? 32'h0 : 32'h2 * e);
      rd(`ADDR_CHAN_COUNT);
      chk("count edge kind", cnt, d);
    end
  endtask

  // mode field changed while stopped: restart value is not relied upon
  task automatic t_mode;
    logic [31:0] a;
    wr(`ADDR_CHAN_MODE_CFG, 32'h0001, `LANES_16);
    wr(`ADDR_CHAN_CTRL, 32'h1, 4'hF);
    chk("running", 32'h1, {31'h0, o_counter_enable_status});
    rd(`ADDR_CHAN_COUNT);
    a = d;
    pulse(4'h1, 2);
    wr(`ADDR_CHAN_CTRL, 32'h2, 4'hF);
    chk("stopped", 32'h0, {31'h0, o_counter_enable_status});
    rd(`ADDR_CHAN_COUNT);
    chk("count after mode change", a + 32'h2, d);
  endtask

  // running writes and narrow writes leave the register alone
  task automatic t_refuse;
    wr(`ADDR_CHAN_MODE_CFG, 32'h4000, `LANES_16);
    wr(`ADDR_CHAN_CTRL, 32'h1, 4'hF);
    chk("running before refusal", 32'h1, {31'h0, o_counter_enable_status});
    wr(`ADDR_CHAN_MODE_CFG, 32'h8800, `LANES_16);
    wr(`ADDR_CHAN_CTRL, 32'h2, 4'hF);
    rd(`ADDR_CHAN_MODE_CFG);
    chk("cfg after refusal", 32'h4000, d);
    chk("role after refusal", 32'h0, {31'h0, o_master_slave_role});
    rd(`ADDR_CHAN_STATUS);
    chk("refusal flag", 32'h2, d);
    wr(`ADDR_CHAN_STATUS, 32'h2, 4'hF);
    wr(`ADDR_CHAN_MODE_CFG, 32'h8000, 4'h1);
    rd(`ADDR_CHAN_MODE_CFG);
    chk("cfg narrow write", 32'h4000, d);
    rd(8'h40);
    chk("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask

  // reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'h1;
    @(posedge i_ref_clk);
    rd(`ADDR_CHAN_MODE_CFG);
    chk("cfg reset", {16'h0, `MODE_CFG_RESET}, d);
    t_clocks();
    t_sources();
    t_edges();
    t_mode();
    t_refuse();
    report_and_stop();
  end
endmodule // timer_channel_mode_config_tb_top
